// [logic/ftbs_regs.vh]
// Constants for the flow-through burst memory core.
// Included by the core and its output buffer; definitions only.
`ifndef FTBS_REGS_VH
`define FTBS_REGS_VH
`define FTBS_ADDR_W 17
`define FTBS_DEPTH 131072
`define FTBS_LANE_W 9
`define FTBS_DATA_W 18
`define FTBS_LANES 2
`define FTBS_BURST_W 2
`define FTBS_BURST_ZERO 2'h0
`define FTBS_BURST_ONE 2'h1
`define FTBS_LANE_MASK_ALL 2'h3
`define FTBS_LANE_MASK_NONE 2'h0
`define FTBS_BUF_EMPTY 2'h0
`define FTBS_BUF_ONE 2'h1
`define FTBS_BUF_FULL 2'h2
`define FTBS_ST_IDLE 2'h0
`define FTBS_ST_READ 2'h1
`define FTBS_ST_WRITE 2'h2
`define FTBS_ST_SLEEP 2'h3
`endif

// [logic/ftbs_out_buf.v]
// Two-entry buffer in the read data path.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "ftbs_regs.vh"
module ftbs_out_buf (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Fill side
    input wire inValid,
    output wire inReady,
    input wire [`FTBS_DATA_W-1:0] inData,
    // Drain side
    output wire outValid,
    input wire outReady,
    output wire [`FTBS_DATA_W-1:0] outData
);
    reg [`FTBS_DATA_W-1:0] slot_q [0:1];
    reg rdPtr_q;
    reg wrPtr_q;
    reg [1:0] count_q;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = (count_q != `FTBS_BUF_FULL);
    assign outValid = (count_q != `FTBS_BUF_EMPTY);
    assign outData = slot_q[rdPtr_q];

    always @(posedge core_clk) begin
        if (rst) begin
            rdPtr_q <= 1'b0;
            wrPtr_q <= 1'b0;
            count_q <= `FTBS_BUF_EMPTY;
        end else begin
            if (push) begin
                slot_q[wrPtr_q] <= inData;
                wrPtr_q <= ~wrPtr_q;
            end
            if (pop)
                rdPtr_q <= ~rdPtr_q;
            if (push && !pop)
                count_q <= count_q + `FTBS_BUF_ONE;
            else if (pop && !push)
                count_q <= count_q - `FTBS_BUF_ONE;
        end
    end
endmodule // ftbs_out_buf

// [logic/ftbs_core.v]
// Flow-through burst memory core, 128K words of two 9-bit lanes.
// Assumes all pins but sleep_req synchronous to core_clk; the bench resolves the data wire.
`timescale 1ns/1ps
`include "ftbs_regs.vh"
// Contract
// - All synchronous inputs sampled only on core_clk rising edge.
// - Address captured when a strobe is accepted and all selects are active.
// - Captured address low two bits seed the burst counter.
// - Two-bit burst counter wraps after four, generating addresses internally.
// - Burst counter steps on each edge with burst_step_n low; code steps only with no strobe accepted, awake, in a read or write state.
// - burstOrder low linear, high interleaved; held static by host.
// - Interleaved position is start XOR step count.
// - Linear position is start plus step count, modulo four.
// - Both strobes low: processor strobe wins, controller strobe ignored.
// - Processor strobe ignored while chip_sel1_n is high.
// - Selects sampled only when loading a new external address.
// - all_bytes_write_n low writes both lanes regardless of byte inputs.
// - Byte write writes only lanes whose select is low, gated.
// - Byte select A maps to lane A with parity, B likewise.
// - Processor strobe always starts a read; writes come later or via controller.
// - Output enable high tristates data; low drives outside writes.
// - First read clock after deselect keeps data tristated.
// - Read data follows its address edge with no extra stage.
// - Write data registered from data pins at rising edge.
// - Writes complete internally in the edge they are presented.
// - Bursts of four run 2-1-1-1.
// - sleep_req high enters retention; stored data kept.
module ftbs_core (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Address and selects
    input wire [`FTBS_ADDR_W-1:0] addrIn,
    input wire chip_sel1_n,
    input wire chip_sel2,
    input wire chip_sel3_n,
    // Burst control
    input wire proc_addr_strobe_n,
    input wire ctrl_addr_strobe_n,
    input wire burst_step_n,
    input wire burstOrder,
    // Write controls
    input wire all_bytes_write_n,
    input wire byte_write_gate_n,
    input wire [`FTBS_LANES-1:0] byte_select_n,
    // Output enable and sleep
    input wire outEnable_n,
    input wire sleep_req,
    // Data pins, lane B high, parity at the top of each lane
    input wire [`FTBS_DATA_W-1:0] dataIn,
    output wire [`FTBS_DATA_W-1:0] dataOut,
    output wire dataOe,
    // Read stream with back-pressure
    output wire rdValid,
    input wire rdReady,
    output wire [`FTBS_DATA_W-1:0] rdData,
    // Status
    output wire asleep,
    output wire stallOut
);
    wire [`FTBS_DATA_W-1:0] memRd;
    reg [`FTBS_ADDR_W-1:0] base_q;
    reg [`FTBS_BURST_W-1:0] start_q;
    reg [`FTBS_BURST_W-1:0] step_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg freshRead_q;
    reg [`FTBS_DATA_W-1:0] rdWord_q;
    reg rdPush_q;
    reg [1:0] sleepSync_q;

    function [`FTBS_BURST_W-1:0] burstPos;
        input order;
        input [`FTBS_BURST_W-1:0] start;
        input [`FTBS_BURST_W-1:0] step;
        begin
            if (order)
                burstPos = start ^ step;
            else
                burstPos = start + step;
        end
    endfunction

    // Strobe acceptance and selection
    wire procAcc = !proc_addr_strobe_n && !chip_sel1_n;
    // A processor strobe ignored for chip_sel1_n high leaves the controller strobe in force
    wire ctrlAcc = !ctrl_addr_strobe_n && !procAcc;
    wire strobeAcc = procAcc || ctrlAcc;
    wire selected = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
    wire load = strobeAcc && selected;
    wire deselect = strobeAcc && !selected;

    // Write qualification; a processor-strobe edge is always a read
    wire gateWrite = !byte_write_gate_n && (byte_select_n != `FTBS_LANE_MASK_ALL);
    wire anyWrite = !all_bytes_write_n || gateWrite;
    wire isWrite = anyWrite && !(procAcc && load);
    wire [`FTBS_LANES-1:0] laneWe =
        !all_bytes_write_n ? `FTBS_LANE_MASK_ALL :
        (byte_write_gate_n ? `FTBS_LANE_MASK_NONE : ~byte_select_n);

    // Burst address: the edge's address is the one used
    wire [`FTBS_BURST_W-1:0] nextStep = burst_step_n ? step_q : step_q + `FTBS_BURST_ONE;
    wire [`FTBS_BURST_W-1:0] curPos = burstPos(burstOrder, start_q, nextStep);
    wire [`FTBS_ADDR_W-1:0] contAddr = {base_q[`FTBS_ADDR_W-1:`FTBS_BURST_W], curPos};
    wire [`FTBS_ADDR_W-1:0] accAddr = load ? addrIn : contAddr;
    wire active = (state_q == `FTBS_ST_READ) || (state_q == `FTBS_ST_WRITE);
    wire doAccess = !asleep && (load || (!strobeAcc && active));
    wire bufReady;

    always @* begin
        state_d = state_q;
        case (state_q)
            `FTBS_ST_SLEEP: state_d = `FTBS_ST_IDLE;
            `FTBS_ST_IDLE, `FTBS_ST_READ, `FTBS_ST_WRITE: begin
                if (deselect)
                    state_d = `FTBS_ST_IDLE;
                else if (doAccess)
                    state_d = isWrite ? `FTBS_ST_WRITE : `FTBS_ST_READ;
            end
            default: state_d = `FTBS_ST_IDLE;
        endcase
        // Sleep overrides the next state; an access presented at this edge still completes
        if (sleepSync_q[1])
            state_d = `FTBS_ST_SLEEP;
    end

    // Sleep is asynchronous at the pin, so it is resynchronised; three clocks to enter
    always @(posedge core_clk) begin
        if (rst)
            sleepSync_q <= 2'h0;
        else
            sleepSync_q <= {sleepSync_q[0], sleep_req};
    end
    assign asleep = (state_q == `FTBS_ST_SLEEP);

    always @(posedge core_clk) begin
        if (rst) begin
            base_q <= {`FTBS_ADDR_W{1'b0}};
            start_q <= `FTBS_BURST_ZERO;
            step_q <= `FTBS_BURST_ZERO;
            state_q <= `FTBS_ST_IDLE;
            freshRead_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (!asleep && load) begin
                base_q <= addrIn;
                start_q <= addrIn[`FTBS_BURST_W-1:0];
                step_q <= `FTBS_BURST_ZERO;
            end else if (!asleep && !strobeAcc && active) begin
                step_q <= nextStep;
            end
            freshRead_q <= (state_q != `FTBS_ST_READ) && (state_d == `FTBS_ST_READ)
                && (state_q != `FTBS_ST_WRITE);
        end
    end

    // Self-timed write: data registered and stored at the same edge
    // Each lane owns its array, so every array has a single writer
    genvar g;
    generate
        for (g = 0; g < `FTBS_LANES; g = g + 1) begin : laneWr
            reg [`FTBS_LANE_W-1:0] laneMem [0:`FTBS_DEPTH-1];
            always @(posedge core_clk) begin
                if (doAccess && isWrite && laneWe[g])
                    laneMem[accAddr] <=
                        dataIn[g*`FTBS_LANE_W +: `FTBS_LANE_W];
            end
            assign memRd[g*`FTBS_LANE_W +: `FTBS_LANE_W] = laneMem[accAddr];
        end
    endgenerate

    // Read word after its own address edge; no further stage
    always @(posedge core_clk) begin
        if (rst) begin
            rdWord_q <= {`FTBS_DATA_W{1'b0}};
            rdPush_q <= 1'b0;
        end else begin
            rdPush_q <= doAccess && !isWrite;
            if (doAccess && !isWrite)
                rdWord_q <= memRd;
        end
    end

    assign dataOut = rdWord_q;
    // Masked during writes and the first read after a deselect
    assign dataOe = (state_q == `FTBS_ST_READ) && !outEnable_n && !freshRead_q;
    // Stream copy of read words; a word read while the buffer is full is dropped, stallOut flags it
    assign stallOut = !bufReady;

    ftbs_out_buf u_buf (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(rdPush_q),
        .inReady(bufReady),
        .inData(rdWord_q),
        .outValid(rdValid),
        .outReady(rdReady),
        .outData(rdData)
    );
endmodule // ftbs_core

// [sim/ftbs_props.sv]
// Port checker for the burst memory core.
// Assumes it is bound onto ftbs_core with one clock and sync reset.
`timescale 1ns/1ps
module ftbs_props (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Selects and strobes
    input wire chip_sel1_n,
    input wire chip_sel2,
    input wire chip_sel3_n,
    input wire proc_addr_strobe_n,
    input wire ctrl_addr_strobe_n,
    // Write, output enable and sleep
    input wire all_bytes_write_n,
    input wire outEnable_n,
    input wire sleep_req,
    // Watched outputs
    input wire dataOe,
    input wire rdValid,
    input wire asleep,
    input wire stallOut
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire selOk = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
    wire procGo = !proc_addr_strobe_n && !chip_sel1_n;
    wire anyGo = procGo || !ctrl_addr_strobe_n;
    wire awake = !asleep && !sleep_req;
    a_oe_high_quiet: assert property (outEnable_n |-> !dataOe)
        else $error("data driven with output enable high");
    a_sleep_quiet: assert property (asleep |-> !dataOe)
        else $error("data driven while asleep");
    a_deselect_quiet: assert property (awake && anyGo && !selOk |=> !dataOe)
        else $error("data driven after deselect");
    a_fresh_read_masked: assert property
        (awake && anyGo && !selOk ##1 awake && procGo && selOk |=> !dataOe)
        else $error("first read after deselect drove data");
    a_read_to_stream: assert property
        (awake && procGo && selOk && !stallOut |-> ##[1:3] rdValid)
        else $error("read word never reached stream");
    a_write_quiet: assert property (awake && !ctrl_addr_strobe_n && proc_addr_strobe_n
        && selOk && !all_bytes_write_n |=> !dataOe) else $error("data driven in write");
    a_sleep_enter: assert property (sleep_req [*5] |-> asleep)
        else $error("sleep not entered");
    a_sleep_exit: assert property (!sleep_req [*5] |-> !asleep)
        else $error("sleep not left");
    c_read: cover property (procGo && selOk);
    c_full: cover property (stallOut);
    c_sleep: cover property (asleep);
endmodule // ftbs_props
bind ftbs_core ftbs_props u_props (.core_clk, .rst, .chip_sel1_n, .chip_sel2, .chip_sel3_n,
    .proc_addr_strobe_n, .ctrl_addr_strobe_n, .all_bytes_write_n, .outEnable_n,
    .sleep_req, .dataOe, .rdValid, .asleep, .stallOut);

// [sim/ftbs_host.sv]
// Host partner: resolves the shared data wire and sinks the read stream.
// Assumes the bench drives hostDrive only while the core is told not to drive.
`timescale 1ns/1ps
module ftbs_host (
    // Clock
    input wire core_clk,
    // Data wire
    input wire [17:0] dataOut,
    input wire dataOe,
    input wire [17:0] hostData,
    input wire hostDrive,
    output logic [17:0] dataIn,
    // Stream sink
    input wire stall,
    output logic rdReady
);
    logic [17:0] floatPat = 18'h2_a5a5;
    // Released wire toggles so a stale word never reads as good
    always @(posedge core_clk) floatPat <= ~floatPat;
    always @* begin
        dataIn = hostDrive ? hostData : (dataOe ? dataOut : floatPat);
        rdReady = !stall;
    end
endmodule // ftbs_host

// [sim/flow_through_burst_sram_bench.sv]
// Self-checking bench for the burst memory core.
// Assumes the host partner and the bound port checker.
`timescale 1ns/1ps
module flow_through_burst_sram_bench;
    logic core_clk = 1'h0, rst = 1'h1, order = 1'h0, stall = 1'h0, hostDrive = 1'h0;
    logic cs1n = 1'h0, cs2 = 1'h1, cs3n = 1'h0, pasn = 1'h1, casn = 1'h1, stepn = 1'h1;
    logic gwn = 1'h1, bwen = 1'h1, oen = 1'h1, sleep = 1'h0;
    logic [1:0] bsn = 2'h3;
    logic [16:0] addrIn = 17'h0_0000, base;
    logic [17:0] hostData = 18'h0_0000;
    wire [17:0] dataIn, dataOut, rdData;
    wire dataOe, rdValid, rdReady, asleep, stallOut;
    logic [17:0] memRef [int];
    int bad_count = 0, checks = 0;
    ftbs_core dut (.core_clk(core_clk), .rst(rst), .addrIn(addrIn), .chip_sel1_n(cs1n),
        .chip_sel2(cs2), .chip_sel3_n(cs3n), .proc_addr_strobe_n(pasn),
        .ctrl_addr_strobe_n(casn), .burst_step_n(stepn), .burstOrder(order),
        .all_bytes_write_n(gwn), .byte_write_gate_n(bwen), .byte_select_n(bsn),
        .outEnable_n(oen), .sleep_req(sleep), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
        .asleep(asleep), .stallOut(stallOut));
    ftbs_host host (.core_clk(core_clk), .dataOut(dataOut), .dataOe(dataOe),
        .hostData(hostData), .hostDrive(hostDrive), .dataIn(dataIn), .stall(stall),
        .rdReady(rdReady));
    initial forever #4 core_clk = ~core_clk;
    task automatic cyc(int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic cmp(logic [17:0] got, logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [1:0] pos(logic ord, logic [1:0] s, logic [1:0] k);
        return ord ? s ^ k : s + k;
    endfunction
    // Leaves the processor strobe low and chip_sel2 low; caller releases them
    task automatic dsel();
        pasn = 1'h0; cs2 = 1'h0;
        casn = 1'h1; gwn = 1'h1; bwen = 1'h1; bsn = 2'h3; hostDrive = 1'h0;
        cyc();
    endtask
    task automatic wr(logic [16:0] a, logic [17:0] d, logic g, logic [1:0] b);
        casn = 1'h0; addrIn = a; gwn = g; bwen = !g; bsn = b; oen = 1'h1;
        hostDrive = 1'h1; hostData = d;
        if (!g) memRef[a] = d;
        else for (int l = 0; l < 2; l++) if (!b[l]) memRef[a][l*9 +: 9] = d[l*9 +: 9];
        // Controls stay up so back-to-back writes need no idle edge; dsel drops them
        cyc();
    endtask
    task automatic burst(logic [16:0] a, logic ord);
        dsel();
        order = ord; pasn = 1'h0; cs2 = 1'h1; addrIn = a; oen = 1'h0;
        cyc();
        cmp(dataOe, 1'h0);
        for (int k = 0; k < 6; k++) begin
            cmp(dataOut, memRef[{a[16:2], pos(ord, a[1:0], (k < 5) ? k[1:0] : 2'h0)}]);
            if (k == 1) cmp(dataOe, 1'h1);
            pasn = (k != 2); cs1n = (k == 2); cs2 = (k == 5) | 1'($urandom);
            // Last pass leaves idle values, so the next task starts on a fresh time step
            stepn = (k >= 4);
            cyc();
        end
    endtask
    task automatic stop_test;
        $display("Mismatches %0d, checks %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #50000;
        bad_count++;
        stop_test;
    end
    initial begin
        void'($urandom(10));
        cyc(16);
        rst = 1'h0;
        stall = 1'h1;
        for (int i = 0; i < 8; i++) begin
            base = $urandom;
            base[1:0] = 2'h0;
            for (int j = 0; j < 4; j++) wr({base[16:2], 2'(j)}, $urandom, 1'h0, 2'h3);
            wr(base + 17'h0_0001, $urandom, 1'h1, i[1:0]);
            burst(base + 17'(i[1:0]), i[2]);
        end
        cmp(stallOut, 1'h1);
        // A live burst repeats its read every edge, so deselect before draining
        dsel();
        pasn = 1'h1; cs2 = 1'h1; stall = 1'h0;
        cyc(4);
        cmp({rdValid, stallOut}, 2'h0);
        // Both strobes with write asserted must read, not write
        pasn = 1'h0; casn = 1'h0; gwn = 1'h0; oen = 1'h1; addrIn = base; hostDrive = 1'h1;
        hostData = ~memRef[base];
        cyc();
        dsel();
        cmp(rdValid, 1'h1);
        cmp(rdData, memRef[base]);
        burst(base, 1'h0);
        dsel();
        pasn = 1'h1; cs2 = 1'h1; sleep = 1'h1;
        cyc(6);
        cmp(asleep, 1'h1);
        sleep = 1'h0;
        cyc(6);
        cmp(asleep, 1'h0);
        burst(base, 1'h1);
        stop_test;
    end
endmodule // flow_through_burst_sram_bench
